// ===== logic/stu_map.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the stator third-harmonic undervoltage block.
 * Assumes a 10 MHz system clock and byte addresses on a 32-bit port.
 */
`ifndef STU_MAP_SVH
`define STU_MAP_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define STU_CLK_NS 100
`define STU_TICK_NS 5000000
`define STU_TICK_CLKS (`STU_TICK_NS / `STU_CLK_NS)
`define STU_STEP_MS 5
`define STU_DLY_MS_DEF 40
`define STU_DLY_DEF (`STU_DLY_MS_DEF / `STU_STEP_MS)
// ****************************************************************
// Register offsets
// ****************************************************************
`define STU_A_CTRL 8'h00
`define STU_A_THR0 8'h04
`define STU_A_DLY0 8'h08
`define STU_A_LOWI0 8'h0c
`define STU_A_THR1 8'h10
`define STU_A_DLY1 8'h14
`define STU_A_LOWI1 8'h18
`define STU_A_VTPRI 8'h1c
`define STU_A_STAT 8'h20
`define STU_A_RATIO 8'h24
`define STU_A_MPCT 8'h28
`define STU_A_MPRI 8'h2c
`define STU_A_THRV 8'h30
`define STU_A_EXPT 8'h34
`define STU_A_REMT 8'h38
`define STU_A_IRQS 8'h3c
`define STU_A_IRQM 8'h40
// ****************************************************************
// Fields and reset values
// ****************************************************************
`define STU_F_MODE 2:0
`define STU_F_FORCE 4:3
`define STU_B_FEN 5
`define STU_B_RES3 6
`define STU_B_RES4 7
`define STU_F_SEL 9:8
`define STU_B_GRP 10
`define STU_CTRL_RST 11'h200
`define STU_THR_DEF 16'h07d0
`define STU_HYST_PCT 16'h0067
`define STU_PCT_FULL 16'h0064
`define STU_RATIO_SCALE 16'h2710
`define STU_VTPRI_DEF 16'h0064
`define STU_DIV_STEPS 6'h20
`endif

// ===== logic/stu_pkg.sv
/*
 * Types of the stator third-harmonic undervoltage block.
 * Assumes the constants of stu_map.svh.
 */
`default_nettype none
package stu_pkg;
    typedef enum logic [2:0] {M_ON, M_BLK, M_TEST, M_TBLK, M_OFF} stu_mode_t;
    typedef enum logic [1:0] {C_NORMAL, C_START, C_TRIP, C_BLOCKED} stu_cond_t;
    typedef enum logic [1:0] {CH_NONE, CH_THREE, CH_FOUR} stu_chan_t;
    // One setting group
    typedef struct packed {
        logic [15:0] thr;
        logic [15:0] dly;
        logic [15:0] lowi;
    } stu_grp_t;
    // Measurement front end, refreshed every cycle
    typedef struct packed {
        logic [15:0] u3h_ch3;
        logic [15:0] u3h_ch4;
        logic [15:0] il1;
        logic [15:0] il2;
        logic [15:0] il3;
    } stu_meas_t;
    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } stu_bus_t;
    // Whole module state
    typedef struct packed {
        logic [10:0] ctrl;
        stu_grp_t [1:0] grp;
        logic [15:0] vtpri;
        logic [2:0] irqs;
        logic [2:0] irqm;
        logic [31:0] rdata;
        logic [15:0] tick;
        logic [15:0] meas;
        logic [15:0] dcnt;
        logic picked;
        stu_cond_t st;
        stu_chan_t chan;
        logic [31:0] ratio;
        logic [31:0] num;
        logic [32:0] rem;
        logic [31:0] quo;
        logic [15:0] den;
        logic [5:0] dstep;
    } stu_state_t;
endpackage
`default_nettype wire

// ===== logic/stu_stator_third_harm_undervoltage.sv
/*
 * Stator earth-fault detection by third-harmonic neutral undervoltage.
 * Holds the processing cycle, channel choice, pick-up with hysteresis,
 * low-current supervision, definite-time delay, mode and forcing,
 * register port and interrupt.
 * Assumes measurement inputs and the blocking input come from logic
 * on i_clk_sys, and a plain register port with read data next cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "stu_map.svh"
module stu_stator_third_harm_undervoltage
    import stu_pkg::*;
#(
    parameter logic [15:0] TICK_CLKS = 16'(`STU_TICK_CLKS)
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire stu_meas_t i_meas,
    input wire logic i_stator_fault_block,
    input wire stu_bus_t i_bus,
    output logic [31:0] o_rdata,
    output logic o_start,
    output logic o_trip,
    output logic o_blocked,
    output logic o_irq
);
    // ****************************************************************
    // State registers
    // ****************************************************************
    stu_state_t s_q;
    stu_state_t s_d;

    // ****************************************************************
    // Derived values from current state
    // ****************************************************************
    stu_grp_t g;
    stu_mode_t mode;
    stu_cond_t cond;
    logic tick_now;
    logic [17:0] isum;
    logic [15:0] ipos;
    logic [15:0] usel;
    logic [31:0] hyst_m;
    logic [31:0] hyst_t;
    logic pu_cond;
    logic rel_cond;
    logic picked_n;
    logic allow;
    logic mblk;
    logic [15:0] remt;
    logic [31:0] mpri;
    logic [31:0] thrv;
    logic [2:0] ev;
    stu_chan_t s_d_chan_w;

    // Group chosen live, so a switch acts on the very next cycle
    assign g = s_q.ctrl[`STU_B_GRP] ? s_q.grp[1] : s_q.grp[0];
    assign mode = stu_mode_t'(s_q.ctrl[`STU_F_MODE]);
    assign tick_now = (s_q.tick == TICK_CLKS - 16'h0001);
    assign mblk = (mode == M_BLK) || (mode == M_TBLK);

    // Magnitudes only: balanced phases assumed, so the mean stands in
    assign isum = 18'(i_meas.il1) + 18'(i_meas.il2) + 18'(i_meas.il3);
    assign ipos = 16'(isum / 18'h00003);
    assign allow = (g.lowi == 16'h0000) || (ipos >= g.lowi);

    // Channel in use from the residual roles and the selector
    always_comb begin
        stu_chan_t ch;
        ch = CH_NONE;
        if (s_q.ctrl[`STU_B_RES3] && s_q.ctrl[`STU_B_RES4]) begin
            if (s_q.ctrl[`STU_F_SEL] == 2'h0) begin
                ch = CH_THREE;
            end else if (s_q.ctrl[`STU_F_SEL] == 2'h1) begin
                ch = CH_FOUR;
            end
        end else if (s_q.ctrl[`STU_B_RES3]) begin
            ch = CH_THREE;
        end else if (s_q.ctrl[`STU_B_RES4]) begin
            ch = CH_FOUR;
        end
        s_d_chan_w = ch;
    end

    // Operating quantity from the chosen channel only
    assign usel = (s_d_chan_w == CH_FOUR) ? i_meas.u3h_ch4 : i_meas.u3h_ch3;
    assign hyst_m = 32'(usel) * 32'(`STU_PCT_FULL);
    assign hyst_t = 32'(g.thr) * 32'(`STU_HYST_PCT);
    assign pu_cond = (s_d_chan_w != CH_NONE) && (usel < g.thr);
    assign rel_cond = (s_d_chan_w == CH_NONE) || (hyst_m > hyst_t);
    assign picked_n = s_q.picked ? !rel_cond : pu_cond;

    // Condition shown, forcing overrides the live state
    always_comb begin
        if (s_q.ctrl[`STU_B_FEN]) begin
            cond = stu_cond_t'(s_q.ctrl[`STU_F_FORCE]);
        end else if (mode == M_OFF) begin
            cond = C_NORMAL;
        end else begin
            cond = s_q.st;
        end
    end

    // Primary scaling of measurement and threshold
    assign mpri = (32'(s_q.meas) * 32'(s_q.vtpri)) / 32'h0000_0064;
    assign thrv = (32'(g.thr) * 32'(s_q.vtpri)) / 32'h0000_03e8;
    assign remt = (s_q.st == C_START) ? (g.dly - s_q.dcnt) : 16'h0000;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        logic [32:0] r;
        r = 33'h0_0000_0000;
        s_d = s_q;
        ev = 3'h0;
        s_d.rdata = 32'h0000_0000;
        s_d.tick = tick_now ? 16'h0000 : s_q.tick + 16'h0001;
        s_d.chan = s_d_chan_w;

        // Evaluation once per processing cycle
        if (tick_now) begin
            s_d.meas = usel;
            s_d.picked = picked_n;
            if (!picked_n || mode == M_OFF) begin
                s_d.st = C_NORMAL;
                s_d.dcnt = 16'h0000;
            end else begin
                unique case (s_q.st)
                    C_NORMAL: begin
                        if (i_stator_fault_block || mblk) begin
                            s_d.st = C_BLOCKED;
                        end else if (g.dly == 16'h0000 && allow) begin
                            s_d.st = C_TRIP;
                        end else begin
                            s_d.st = C_START;
                        end
                    end
                    C_START: begin
                        if (i_stator_fault_block || mblk) begin
                            // Block after start resets as on release
                            s_d.st = C_NORMAL;
                            s_d.dcnt = 16'h0000;
                        end else begin
                            if (s_q.dcnt < g.dly) begin
                                s_d.dcnt = s_q.dcnt + 16'h0001;
                            end
                            if (s_q.dcnt + 16'h0001 >= g.dly && allow) begin
                                s_d.st = C_TRIP;
                            end
                        end
                    end
                    C_TRIP: s_d.st = C_TRIP;
                    C_BLOCKED: s_d.st = C_BLOCKED;
                endcase
            end
            // Ratio division launched on each fresh sample
            s_d.num = 32'(usel) * 32'(`STU_RATIO_SCALE);
            s_d.den = g.thr;
            s_d.rem = 33'h0_0000_0000;
            s_d.quo = 32'h0000_0000;
            s_d.dstep = `STU_DIV_STEPS;
        end else if (s_q.dstep != 6'h00) begin
            // One restoring step per clock; a zero threshold saturates
            r = {s_q.rem[31:0], s_q.num[31]};
            s_d.num = {s_q.num[30:0], 1'b0};
            if (r >= 33'(s_q.den)) begin
                s_d.rem = r - 33'(s_q.den);
                s_d.quo = {s_q.quo[30:0], 1'b1};
            end else begin
                s_d.rem = r;
                s_d.quo = {s_q.quo[30:0], 1'b0};
            end
            s_d.dstep = s_q.dstep - 6'h01;
            if (s_q.dstep == 6'h01) begin
                s_d.ratio = s_d.quo;
            end
        end

        // Interrupt events: start, trip and blocked entries
        ev[0] = (s_d.st == C_START) && (s_q.st != C_START);
        ev[1] = (s_d.st == C_TRIP) && (s_q.st != C_TRIP);
        ev[2] = (s_d.st == C_BLOCKED) && (s_q.st != C_BLOCKED);

        // Register writes
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                `STU_A_CTRL: s_d.ctrl = i_bus.wdata[10:0];
                `STU_A_THR0: s_d.grp[0].thr = i_bus.wdata[15:0];
                `STU_A_DLY0: s_d.grp[0].dly = i_bus.wdata[15:0];
                `STU_A_LOWI0: s_d.grp[0].lowi = i_bus.wdata[15:0];
                `STU_A_THR1: s_d.grp[1].thr = i_bus.wdata[15:0];
                `STU_A_DLY1: s_d.grp[1].dly = i_bus.wdata[15:0];
                `STU_A_LOWI1: s_d.grp[1].lowi = i_bus.wdata[15:0];
                `STU_A_VTPRI: s_d.vtpri = i_bus.wdata[15:0];
                `STU_A_IRQS: s_d.irqs = s_q.irqs & ~i_bus.wdata[2:0];
                `STU_A_IRQM: s_d.irqm = i_bus.wdata[2:0];
                default: ;
            endcase
        end
        // Set after the clear so a same-cycle event is kept
        s_d.irqs = s_d.irqs | ev;

        // Register reads, answered on the next cycle
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `STU_A_CTRL: s_d.rdata = 32'(s_q.ctrl);
                `STU_A_THR0: s_d.rdata = 32'(s_q.grp[0].thr);
                `STU_A_DLY0: s_d.rdata = 32'(s_q.grp[0].dly);
                `STU_A_LOWI0: s_d.rdata = 32'(s_q.grp[0].lowi);
                `STU_A_THR1: s_d.rdata = 32'(s_q.grp[1].thr);
                `STU_A_DLY1: s_d.rdata = 32'(s_q.grp[1].dly);
                `STU_A_LOWI1: s_d.rdata = 32'(s_q.grp[1].lowi);
                `STU_A_VTPRI: s_d.rdata = 32'(s_q.vtpri);
                `STU_A_STAT: s_d.rdata = 32'({s_q.chan, cond, mode});
                `STU_A_RATIO: s_d.rdata = s_q.ratio;
                `STU_A_MPCT: s_d.rdata = 32'(s_q.meas);
                `STU_A_MPRI: s_d.rdata = mpri;
                `STU_A_THRV: s_d.rdata = thrv;
                `STU_A_EXPT: s_d.rdata = 32'(g.dly);
                `STU_A_REMT: s_d.rdata = 32'(remt);
                `STU_A_IRQS: s_d.rdata = 32'(s_q.irqs);
                `STU_A_IRQM: s_d.rdata = 32'(s_q.irqm);
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.ctrl <= `STU_CTRL_RST;
            s_q.grp[0] <= '{`STU_THR_DEF, 16'(`STU_DLY_DEF), 16'h0000};
            s_q.grp[1] <= '{`STU_THR_DEF, 16'(`STU_DLY_DEF), 16'h0000};
            s_q.vtpri <= `STU_VTPRI_DEF;
            s_q.st <= C_NORMAL;
            s_q.chan <= CH_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Test modes show the condition and keep start and trip quiet, but o_blocked still follows it
    assign o_start = (mode == M_ON) && (cond == C_START || cond == C_TRIP);
    assign o_trip = (mode == M_ON) && (cond == C_TRIP);
    assign o_blocked = (mode != M_OFF) && (cond == C_BLOCKED);
    assign o_rdata = s_q.rdata;
    assign o_irq = |(s_q.irqs & s_q.irqm);
endmodule // stu_stator_third_harm_undervoltage
`default_nettype wire

// ===== sim/stu_checker.sv
/* Port checker for the stator third-harmonic undervoltage block.
   Assumes one system clock with an active-high asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
`include "stu_map.svh"
module stu_checker
    import stu_pkg::*;
#(
    parameter logic [15:0] TICK_CLKS = 16'h0014
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire stu_bus_t i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic o_start,
    input wire logic o_trip,
    input wire logic o_blocked,
    input wire logic o_irq
);
    logic [15:0] tick_q;
    logic tick_now;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    // Mirror of the processing cycle, so output moves can be tied to it
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= tick_now ? 16'h0000 : tick_q + 16'h0001;
        end
    end
    assign tick_now = tick_q == TICK_CLKS - 16'h0001;
    chk_rdata_quiet: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
    chk_trip_has_start: assert property (o_trip |-> o_start)
        else $error("trip without start");
    chk_start_excl_blk: assert property (o_start |-> !o_blocked)
        else $error("start and blocked together");
    chk_start_on_tick: assert property ($changed(o_start) |-> $past(tick_now) || $past(i_bus.wr))
        else $error("start moved between ticks");
    chk_trip_on_tick: assert property ($changed(o_trip) |-> $past(tick_now) || $past(i_bus.wr))
        else $error("trip moved between ticks");
    chk_stat_trip: assert property (i_bus.rd && i_bus.addr == `STU_A_STAT |=>
        (o_rdata[4:3] == 2'h2 && o_rdata[2:0] == 3'h0) == $past(o_trip))
        else $error("status and trip output disagree");
    chk_stat_blk: assert property (i_bus.rd && i_bus.addr == `STU_A_STAT |=>
        (o_rdata[4:3] == 2'h3 && o_rdata[2:0] != 3'h4) == $past(o_blocked))
        else $error("status and blocked output disagree");
    chk_stat_fields: assert property (i_bus.rd && i_bus.addr == `STU_A_STAT |=>
        o_rdata[31:7] == 25'h0 && o_rdata[6:5] != 2'h3 && o_rdata[2:0] <= 3'h4)
        else $error("status field out of range");
endmodule // stu_checker
bind stu_stator_third_harm_undervoltage stu_checker #(.TICK_CLKS(TICK_CLKS)) stu_checker_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
    .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked), .o_irq(o_irq));
`default_nettype wire

// ===== sim/stu_front_model.sv
/* Measurement front end model: harmonic voltages and phase magnitudes.
   Assumes the bench sets the wanted levels on the system clock. */
`timescale 1ns/1ps
`default_nettype none
module stu_front_model
    import stu_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [15:0] i_u_ch3,
    input wire logic [15:0] i_u_ch4,
    input wire logic [15:0] i_i_pos,
    output stu_meas_t o_meas
);
    // Phases spread round the wanted level, so the block must really average them
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_meas <= '0;
        end else begin
            o_meas.u3h_ch3 <= i_u_ch3;
            o_meas.u3h_ch4 <= i_u_ch4;
            o_meas.il1 <= i_i_pos + 16'h000a;
            o_meas.il2 <= i_i_pos;
            o_meas.il3 <= i_i_pos - 16'h000a;
        end
    end
endmodule // stu_front_model
`default_nettype wire

// ===== sim/testbench.sv
/* Self-checking bench of the stator third-harmonic undervoltage block.
   Assumes the front end model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "stu_map.svh"
module testbench
    import stu_pkg::*;
;
    localparam int TK = 50;
    localparam logic [15:0] LO = 16'h03e8;
    localparam logic [15:0] OK = 16'h0bb8;
    logic clk;
    logic rst;
    logic blk;
    stu_bus_t bus;
    logic [15:0] u3;
    logic [15:0] u4;
    logic [15:0] ip;
    stu_meas_t meas;
    logic [31:0] rdata;
    logic start;
    logic trip;
    logic blocked;
    logic irq;
    logic [2:0] so;
    int miscompares;
    int cmp_count;
    int cyc;
    assign so = {start, trip, blocked};
    stu_front_model stu_front_model_i (.i_clk_sys(clk), .i_rst(rst), .i_u_ch3(u3),
        .i_u_ch4(u4), .i_i_pos(ip), .o_meas(meas));
    // Short processing cycle, still longer than the ratio divider needs
    stu_stator_third_harm_undervoltage #(.TICK_CLKS(16'(TK)))
        stu_stator_third_harm_undervoltage_i (.i_clk_sys(clk), .i_rst(rst), .i_meas(meas),
        .i_stator_fault_block(blk), .i_bus(bus), .o_rdata(rdata), .o_start(start),
        .o_trip(trip), .o_blocked(blocked), .o_irq(irq));
    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        // Read data stand only until the next edge, so look mid-cycle
        @(negedge clk);
        chk($sformatf("reg %h", a), rdata, e);
    endtask
    task automatic fm(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clk);
        u3 <= a;
        u4 <= b;
        ip <= c;
    endtask
    task automatic tk(input int n);
        repeat (n * TK) @(posedge clk);
    endtask
    // Bounded wait for the masked outputs to reach a level
    task automatic wt(input logic [2:0] m, input logic [2:0] v, input string nm);
        int n;
        n = 0;
        // Sample off the launching edge, where the outputs have settled
        @(negedge clk);
        while ((so & m) !== v && n < 12 * TK) begin
            @(negedge clk);
            n++;
        end
        chk(nm, 32'(so & m), 32'(v));
    endtask
    task automatic t_dflt();
        rc(`STU_A_CTRL, 32'h200);
        rc(`STU_A_THR0, 32'h07d0);
        rc(`STU_A_EXPT, 32'h8);
        rc(`STU_A_STAT, 32'h0);
        rc(8'h44, 32'h0);
        $display("defaults done");
    endtask
    task automatic t_trip();
        wr(`STU_A_IRQM, 32'h7);
        wr(`STU_A_CTRL, 32'h40);
        fm(LO, OK, 16'h03e8);
        wt(3'h4, 3'h4, "start");
        rc(`STU_A_STAT, 32'h28);
        tk(2);
        rc(`STU_A_RATIO, 32'h1388);
        rc(`STU_A_MPRI, 32'h03e8);
        rc(`STU_A_THRV, 32'h00c8);
        chk("early trip", 32'(trip), 32'h0);
        wt(3'h2, 3'h2, "trip");
        rc(`STU_A_STAT, 32'h30);
        chk("irq", 32'(irq), 32'h1);
        rc(`STU_A_IRQS, 32'h3);
        wr(`STU_A_IRQS, 32'h3);
        @(posedge clk);
        chk("irq clear", 32'(irq), 32'h0);
        fm(16'h080c, OK, 16'h03e8);
        tk(2);
        chk("hyst hold", 32'(trip), 32'h1);
        fm(16'h080d, OK, 16'h03e8);
        wt(3'h6, 3'h0, "release");
        $display("trip done");
    endtask
    task automatic t_lowi();
        wr(`STU_A_DLY0, 32'h0);
        wr(`STU_A_LOWI0, 32'h01f4);
        fm(LO, OK, 16'h012c);
        wt(3'h4, 3'h4, "low current start");
        tk(2);
        chk("low current trip", 32'(trip), 32'h0);
        fm(LO, OK, 16'h0258);
        wt(3'h2, 3'h2, "current ok trip");
        fm(OK, OK, 16'h0258);
        wt(3'h4, 3'h0, "release");
        wr(`STU_A_LOWI0, 32'h0);
        fm(LO, OK, 16'h0258);
        wt(3'h4, 3'h4, "instant start");
        chk("instant trip", 32'(trip), 32'h1);
        fm(OK, OK, 16'h0258);
        wt(3'h4, 3'h0, "release");
        wr(`STU_A_DLY0, 32'h8);
        $display("low current done");
    endtask
    task automatic t_block();
        wr(`STU_A_IRQS, 32'h7);
        fm(LO, OK, 16'h03e8);
        blk <= 1'b1;
        wt(3'h5, 3'h1, "blocked");
        rc(`STU_A_STAT, 32'h38);
        chk("irq", 32'(irq), 32'h1);
        wr(`STU_A_IRQM, 32'h3);
        @(posedge clk);
        chk("irq masked", 32'(irq), 32'h0);
        wr(`STU_A_IRQS, 32'h4);
        wr(`STU_A_IRQM, 32'h7);
        @(posedge clk);
        chk("irq clear", 32'(irq), 32'h0);
        blk <= 1'b0;
        tk(2);
        chk("blocked held", 32'(so), 32'h1);
        fm(OK, OK, 16'h03e8);
        wt(3'h1, 3'h0, "unblocked");
        $display("block done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 5; m++) begin
            wr(`STU_A_CTRL, 32'h40 | 32'(m));
            tk(1);
            rc(`STU_A_STAT, 32'h20 | 32'(m));
        end
        for (int f = 0; f < 4; f++) begin
            wr(`STU_A_CTRL, 32'h60 | 32'(f * 8));
            @(posedge clk);
            chk("forced", 32'(so), 32'({f == 1 || f == 2, f == 2, f == 3}));
        end
        wr(`STU_A_CTRL, 32'h40);
        tk(1);
        $display("modes done");
    endtask
    task automatic t_group();
        wr(`STU_A_THR1, 32'h0bb8);
        fm(16'h09c4, OK, 16'h03e8);
        tk(2);
        chk("group0 quiet", 32'(so), 32'h0);
        wr(`STU_A_CTRL, 32'h0440);
        wt(3'h4, 3'h4, "group1 start");
        rc(`STU_A_CTRL, 32'h0440);
        rc(`STU_A_THRV, 32'h012c);
        wr(`STU_A_CTRL, 32'h40);
        wt(3'h6, 3'h0, "group0 release");
        fm(OK, OK, 16'h03e8);
        $display("group done");
    endtask
    task automatic t_chan();
        wr(`STU_A_CTRL, 32'h02c0);
        fm(LO, LO, 16'h03e8);
        tk(2);
        rc(`STU_A_STAT, 32'h0);
        chk("no channel", 32'(so), 32'h0);
        wr(`STU_A_CTRL, 32'h01c0);
        fm(LO, OK, 16'h03e8);
        tk(2);
        rc(`STU_A_STAT, 32'h40);
        fm(OK, LO, 16'h03e8);
        wt(3'h4, 3'h4, "channel four start");
        rc(`STU_A_STAT, 32'h48);
        fm(OK, OK, 16'h03e8);
        wt(3'h6, 3'h0, "release");
        $display("channel done");
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Reset, then the scenarios in turn
    initial begin
        rst = 1'b1;
        blk = 1'b0;
        bus = '0;
        u3 = OK;
        u4 = OK;
        ip = 16'h03e8;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_dflt();
        t_trip();
        t_lowi();
        t_block();
        t_modes();
        t_group();
        t_chan();
        close_out();
    end
endmodule // testbench
`default_nettype wire
